//--- common/sat_pkg.sv
// constants shared by the segment address translator files
package sat_pkg;

  // -------------------------------------------------------------------
  // register map (byte addresses on the apb bus)
  // -------------------------------------------------------------------
  localparam logic [11:0] STATUS_OFFSET    = 12'h000;
  localparam logic [11:0] WIDTH_OFFSET     = 12'h004;
  localparam logic [11:0] ERR_ADDR_OFFSET  = 12'h008;
  localparam logic [11:0] XLATE_CNT_OFFSET = 12'h00c;

  // status register field positions
  localparam int STAT_CUR_USER_BIT  = 0;
  localparam int STAT_PREV_USER_BIT = 1;
  localparam int STAT_SHUTDOWN_BIT  = 2;

  // -------------------------------------------------------------------
  // reset values
  // -------------------------------------------------------------------
  localparam logic        CUR_USER_RESET  = 1'b0;  // start in kernel mode
  localparam logic        PREV_USER_RESET = 1'b0;
  localparam logic        SHUTDOWN_RESET  = 1'b1;  // no lookup buffer
  localparam logic [27:0] WIDTH_RESET     = 28'haaaaaaa; // all 32-bit

  // -------------------------------------------------------------------
  // segment codes in virtual address bits 31:29
  // -------------------------------------------------------------------
  localparam logic [2:0] SEG_CACHED   = 3'h4;  // kernel_cached_segment
  localparam logic [2:0] SEG_UNCACHED = 3'h5;  // kernel_uncached_segment
  localparam logic [1:0] SEG_MAPPED   = 2'h3;  // kernel_mapped_segment
  localparam logic [2:0] DIRECT_BASE  = 3'h0;  // physical code, direct

  // -------------------------------------------------------------------
  // sub-region index layout
  // -------------------------------------------------------------------
  localparam int          NUM_REGIONS   = 14;
  localparam logic [3:0]  DIRECT_FIRST  = 4'h0;  // 8 x 64MB
  localparam logic [3:0]  USER_FIRST    = 4'h8;  // 4 x 512MB
  localparam logic [3:0]  MAPPED_FIRST  = 4'hc;  // 2 x 512MB
  localparam logic [2:0]  USER_PHYS_LOW = 3'h2;  // paddr 010 is first

  // port width codes held in each 2-bit field
  localparam logic [1:0] PORT_8  = 2'h0;
  localparam logic [1:0] PORT_16 = 2'h1;
  localparam logic [1:0] PORT_32 = 2'h2;

  // privilege state
  typedef enum logic {
    SAT_KERNEL,
    SAT_USER
  } sat_priv_t;

endpackage : sat_pkg

//--- logic/sat_xlate.sv
// combinational segment decode and width lookup for one address
`timescale 1ns/1ps

module sat_xlate #(
  parameter int FIELD_W = 2
) (
  // request
  input  wire logic [31:0]             vaddr,
  input  wire logic                    user_mode,
  input  wire logic [FIELD_W*14-1:0]   width_fields,
  // result
  output logic      [31:0]             paddr,
  output logic                         cacheable,
  output logic                         addr_error,
  output logic      [3:0]              region_idx,
  output logic      [FIELD_W-1:0]      port_width
);

  // -------------------------------------------------------------------
  // region index from the physical address alone
  // -------------------------------------------------------------------
  function automatic logic [3:0] sat_region(input logic [31:0] pa);
    logic [2:0] ofs;
    ofs = 3'h0;
    if (pa[31:29] == sat_pkg::DIRECT_BASE) begin
      sat_region = sat_pkg::DIRECT_FIRST + {1'b0, pa[28:26]};
    end else if (pa[31:30] == sat_pkg::SEG_MAPPED) begin
      sat_region = sat_pkg::MAPPED_FIRST + {3'h0, pa[29]};
    end else begin
      ofs = pa[31:29] - sat_pkg::USER_PHYS_LOW;
      sat_region = sat_pkg::USER_FIRST + {1'b0, ofs};
    end
  endfunction : sat_region

  // -------------------------------------------------------------------
  // segment decode: only the top three bits steer the mapping
  // -------------------------------------------------------------------
  wire logic [2:0] seg       = vaddr[31:29];
  wire logic       is_user   = ~vaddr[31];
  wire logic       is_cached = seg == sat_pkg::SEG_CACHED;
  wire logic       is_uncach = seg == sat_pkg::SEG_UNCACHED;

  // user segment: 00 -> 01, 01 -> 10, low 30 bits untouched;
  // same path for kernel references, mode is not looked at
  wire logic [1:0] user_top = vaddr[31:30] + 2'h1;

  // reserved ranges get no special case, the segment rule covers them
  assign paddr = is_user   ? {user_top, vaddr[29:0]} :
                 (is_cached | is_uncach)
                           ? {sat_pkg::DIRECT_BASE, vaddr[28:0]}
                           : vaddr;
  assign cacheable  = ~is_uncach;
  assign addr_error = user_mode & vaddr[31];

  // width is chosen by high physical bits plus the width fields
  assign region_idx = sat_region(paddr);
  assign port_width = width_fields[region_idx*FIELD_W +: FIELD_W];

endmodule : sat_xlate

//--- logic/sat_top.sv
// segment address translator with privilege state and apb registers
//
// Contract
// - only top three address bits pick segment
// - user reference with bit31 set is error
// - any exception forces kernel mode
// - return restores saved mode or user mode
// - 100 maps to 000, cacheable
// - 101 maps to 000, uncacheable
// - top bits 11 pass through unchanged
// - user top bits 00->01, 01->10
// - kernel user-segment access translates identically
// - user segment has four 512MB width regions
// - mapped segment has two 512MB regions
// - direct region has eight 64MB regions
// - width from high physical bits plus register
// - physical bits 31:29 identify source segment
// - each region 8, 16 or 32 bits
// - reserved ranges translate like their segment
// - shutdown flag reads one after reset
//
// Decided for this implementation: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps

module sat_top #(
  parameter int FIELD_W = 2
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // core request
  input  wire logic        xl_valid,
  input  wire logic [31:0] xl_vaddr,
  // core events
  input  wire logic        exc_event,
  input  wire logic        exc_return,
  // translation result to bus interface unit
  output logic             rs_valid,
  output logic      [31:0] rs_paddr,
  output logic             rs_cacheable,
  output logic             rs_addr_error,
  output logic      [3:0]  rs_region,
  output logic      [1:0]  rs_port_width,
  // privilege state
  output logic             kernel_mode
);

  // -------------------------------------------------------------------
  // elaboration checks
  // -------------------------------------------------------------------
  // the field packing and register width are built for 2-bit fields
  if (FIELD_W != 2) begin : g_bad_field
    $error("sat_top: FIELD_W must be 2");
  end

  // -------------------------------------------------------------------
  // state
  // -------------------------------------------------------------------
  sat_pkg::sat_priv_t cur_reg;
  sat_pkg::sat_priv_t cur_next;
  sat_pkg::sat_priv_t prev_reg;
  sat_pkg::sat_priv_t prev_next;
  logic [27:0]        width_reg;
  logic [31:0]        err_addr_reg;
  logic [31:0]        xlate_cnt_reg;
  logic               shutdown_reg;
  logic               pready_reg;
  logic               pslverr_reg;
  logic [31:0]        prdata_reg;
  logic               rs_valid_reg;
  logic [31:0]        rs_paddr_reg;
  logic               rs_cach_reg;
  logic               rs_err_reg;
  logic [3:0]         rs_region_reg;
  logic [1:0]         rs_width_reg;
  logic               kernel_reg;

  // -------------------------------------------------------------------
  // translation datapath
  // -------------------------------------------------------------------
  wire logic [31:0] xl_paddr;
  wire logic        xl_cach;
  wire logic        xl_err;
  wire logic [3:0]  xl_region;
  wire logic [1:0]  xl_width;

  sat_xlate #(
    .FIELD_W      (FIELD_W)
  ) u_xlate (
    .vaddr        (xl_vaddr),
    .user_mode    (cur_reg == sat_pkg::SAT_USER),
    .width_fields (width_reg),
    .paddr        (xl_paddr),
    .cacheable    (xl_cach),
    .addr_error   (xl_err),
    .region_idx   (xl_region),
    .port_width   (xl_width)
  );

  // a refused reference is itself an exception
  wire logic req_err   = xl_valid & xl_err;
  wire logic any_exc   = exc_event | req_err;

  // -------------------------------------------------------------------
  // apb decode
  // -------------------------------------------------------------------
  // answer one cycle into the access phase; pready is a flop
  wire logic acc_phase = psel & penable;
  wire logic acc_done  = acc_phase & pready_reg;
  wire logic hit_stat  = paddr == sat_pkg::STATUS_OFFSET;
  wire logic hit_width = paddr == sat_pkg::WIDTH_OFFSET;
  wire logic hit_err   = paddr == sat_pkg::ERR_ADDR_OFFSET;
  wire logic hit_cnt   = paddr == sat_pkg::XLATE_CNT_OFFSET;
  wire logic hit_any   = hit_stat | hit_width | hit_err | hit_cnt;
  wire logic wr_stat   = acc_done & pwrite & hit_stat;
  wire logic wr_width  = acc_done & pwrite & hit_width;
  // a read is answered once, in the cycle before pready rises
  wire logic rd_take   = acc_phase & ~pready_reg & ~pwrite;

  wire logic [31:0] stat_word = {29'h0,
                                 shutdown_reg,
                                 prev_reg == sat_pkg::SAT_USER,
                                 cur_reg == sat_pkg::SAT_USER};

  // read mux; unmapped reads give zero with an error answer
  wire logic [31:0] rd_word =
    hit_stat  ? stat_word :
    hit_width ? {4'h0, width_reg} :
    hit_err   ? err_addr_reg :
    hit_cnt   ? xlate_cnt_reg :
                32'h0;

  // software value for the mode bits, if written this cycle
  wire sat_pkg::sat_priv_t sw_cur  =
    pwdata[sat_pkg::STAT_CUR_USER_BIT] ? sat_pkg::SAT_USER
                                       : sat_pkg::SAT_KERNEL;
  wire sat_pkg::sat_priv_t sw_prev =
    pwdata[sat_pkg::STAT_PREV_USER_BIT] ? sat_pkg::SAT_USER
                                        : sat_pkg::SAT_KERNEL;

  // -------------------------------------------------------------------
  // privilege state machine
  // -------------------------------------------------------------------
  // hardware events beat a software write in the same cycle, so an
  // exception is never lost behind a status update
  always_comb begin
    cur_next  = cur_reg;
    prev_next = prev_reg;
    if (wr_stat) begin
      cur_next  = sw_cur;
      prev_next = sw_prev;
    end
    case (1'b1)
      any_exc: begin
        prev_next = cur_reg;               // save mode at detection
        cur_next  = sat_pkg::SAT_KERNEL;
      end
      exc_return: begin
        cur_next  = prev_reg;
        prev_next = sat_pkg::SAT_USER;
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_reg  <= sat_pkg::SAT_KERNEL;
      prev_reg <= sat_pkg::SAT_KERNEL;
    end else begin
      cur_reg  <= cur_next;
      prev_reg <= prev_next;
    end
  end

  // the kernel flag has a flop of its own, loaded from the same next
  // state as the mode, so the output pin is never a decode of state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      kernel_reg <= 1'b1;
    end else begin
      kernel_reg <= cur_next == sat_pkg::SAT_KERNEL;
    end
  end

  // -------------------------------------------------------------------
  // software registers
  // -------------------------------------------------------------------
  // shutdown flag has no writer: this is the base version, with no
  // lookup buffer to switch on, so it keeps its reset value for good
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shutdown_reg <= sat_pkg::SHUTDOWN_RESET;
    end else begin
      shutdown_reg <= shutdown_reg;
    end
  end

  // region widths, one 2-bit field per sub-region; a write lands
  // only in the answer cycle, never in setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      width_reg <= sat_pkg::WIDTH_RESET;
    end else if (wr_width) begin
      width_reg <= pwdata[27:0];
    end
  end

  // last refused address; a later refusal overwrites it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_addr_reg <= 32'h0;
    end else if (req_err) begin
      err_addr_reg <= xl_vaddr;
    end
  end

  // accepted translations only; the counter wraps silently, so
  // software takes the difference of two reads
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xlate_cnt_reg <= 32'h0;
    end else if (xl_valid & ~req_err) begin
      xlate_cnt_reg <= xlate_cnt_reg + 32'h1;
    end
  end

  // apb handshake: always one wait state, then a one-cycle answer;
  // pslverr rides with pready and never stands on its own
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg  <= acc_phase & ~pready_reg;
      pslverr_reg <= acc_phase & ~pready_reg & ~hit_any;
    end
  end

  // read data stands only while pready is high and is zero otherwise,
  // so a stale word is never mistaken for a fresh answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0;
    end else begin
      prdata_reg <= rd_take ? rd_word : 32'h0;
    end
  end

  // -------------------------------------------------------------------
  // registered translation result
  // -------------------------------------------------------------------
  // request flags: a refused reference is never marked cacheable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rs_valid_reg <= 1'b0;
      rs_err_reg   <= 1'b0;
      rs_cach_reg  <= 1'b0;
    end else begin
      rs_valid_reg <= xl_valid;
      rs_err_reg   <= req_err;
      rs_cach_reg  <= ~req_err & xl_cach;
    end
  end

  // address and width fields; a refused reference carries no address
  // to the bus side, the region index is left for it to ignore
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rs_paddr_reg  <= 32'h0;
      rs_region_reg <= 4'h0;
      rs_width_reg  <= 2'h0;
    end else begin
      rs_paddr_reg  <= req_err ? 32'h0 : xl_paddr;
      rs_region_reg <= xl_region;
      rs_width_reg  <= xl_width;
    end
  end

  // -------------------------------------------------------------------
  // outputs
  // -------------------------------------------------------------------
  // every output is a plain copy of a flop
  assign prdata        = prdata_reg;
  assign pready        = pready_reg;
  assign pslverr       = pslverr_reg;
  assign rs_valid      = rs_valid_reg;
  assign rs_paddr      = rs_paddr_reg;
  assign rs_cacheable  = rs_cach_reg;
  assign rs_addr_error = rs_err_reg;
  assign rs_region     = rs_region_reg;
  assign rs_port_width = rs_width_reg;
  assign kernel_mode   = kernel_reg;

endmodule : sat_top

//--- test/sat_chk.sv
// concurrent checks on the translator ports
`timescale 1ns/1ps

module sat_chk (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  // core side
  input wire logic        xl_valid,
  input wire logic [31:0] xl_vaddr,
  input wire logic        exc_event,
  input wire logic        rs_valid,
  input wire logic [31:0] rs_paddr,
  input wire logic        rs_cacheable,
  input wire logic        rs_addr_error,
  input wire logic [3:0]  rs_region,
  input wire logic        kernel_mode
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // -------------------------------------------------------------------
  // request shapes
  // -------------------------------------------------------------------
  sequence bad_s;
    xl_valid && !kernel_mode && xl_vaddr[31];
  endsequence
  sequence user_s;
    xl_valid && !xl_vaddr[31];
  endsequence
  sequence kern_s;
    xl_valid && kernel_mode;
  endsequence

  result_next_a: assert property (xl_valid |=> rs_valid)
    else $error("no result one cycle after request");
  user_error_a: assert property (bad_s |=> rs_addr_error &&
    rs_paddr == 32'h0 && kernel_mode) else $error("user error missed");
  cached_map_a: assert property (kern_s ##0 xl_vaddr[31:29] == 3'h4
    |=> rs_cacheable && rs_paddr == {3'h0, $past(xl_vaddr[28:0])})
    else $error("cached segment translated wrongly");
  uncached_map_a: assert property (kern_s ##0 xl_vaddr[31:29] == 3'h5
    |=> !rs_cacheable && rs_paddr == {3'h0, $past(xl_vaddr[28:0])})
    else $error("uncached segment translated wrongly");
  mapped_pass_a: assert property (kern_s ##0 &xl_vaddr[31:30]
    |=> rs_paddr == $past(xl_vaddr)) else $error("mapped not passed");
  user_remap_a: assert property (user_s |=> rs_paddr ==
    {$past(xl_vaddr[30]), !$past(xl_vaddr[30]), $past(xl_vaddr[29:0])})
    else $error("user segment remapped wrongly");
  exc_kernel_a: assert property (exc_event |=> kernel_mode)
    else $error("exception did not enter kernel mode");
  direct_region_a: assert property (rs_valid && !rs_addr_error &&
    rs_paddr[31:29] == 3'h0 |-> rs_region == {1'b0, rs_paddr[28:26]})
    else $error("direct region index wrong");
  apb_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("apb answer late");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("slave error without ready");
endmodule : sat_chk

bind sat_top sat_chk chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr),
  .xl_valid(xl_valid), .xl_vaddr(xl_vaddr), .exc_event(exc_event),
  .rs_valid(rs_valid), .rs_paddr(rs_paddr), .rs_cacheable(rs_cacheable),
  .rs_addr_error(rs_addr_error), .rs_region(rs_region),
  .kernel_mode(kernel_mode));

//--- test/sat_core_model.sv
// behavioural core: issues references and exception events
`timescale 1ns/1ps

module sat_core_model (
  // clock
  input  wire logic        pclk,
  // toward the translator
  output logic             xl_valid,
  output logic      [31:0] xl_vaddr,
  output logic             exc_event,
  output logic             exc_return,
  // results
  input  wire logic        rs_valid,
  input  wire logic [31:0] rs_paddr,
  input  wire logic        rs_cacheable,
  input  wire logic        rs_addr_error,
  input  wire logic [3:0]  rs_region,
  input  wire logic [1:0]  rs_port_width
);
  // idle at time zero
  initial begin
    xl_valid = 1'b0;
    xl_vaddr = 32'h0;
    exc_event = 1'b0;
    exc_return = 1'b0;
  end

  // one reference; address inverted on release so stale data never passes
  task automatic xlate(input logic [31:0] va, output logic [31:0] pa,
    output logic cac, output logic err, output logic [3:0] rg,
    output logic [1:0] pw);
    @(posedge pclk);
    xl_valid <= 1'b1;
    xl_vaddr <= va;
    @(posedge pclk);
    xl_valid <= 1'b0;
    xl_vaddr <= ~va;
    @(posedge pclk);
    pa = (rs_valid === 1'b1) ? rs_paddr : 32'hxxxx_xxxx;
    cac = rs_cacheable;
    err = rs_addr_error;
    rg = rs_region;
    pw = rs_port_width;
  endtask : xlate

  // one-cycle exception or return pulse, then one cycle to settle
  task automatic ev(input logic ret);
    @(posedge pclk);
    exc_event <= !ret;
    exc_return <= ret;
    @(posedge pclk);
    exc_event <= 1'b0;
    exc_return <= 1'b0;
    @(posedge pclk);
  endtask : ev
endmodule : sat_core_model

//--- test/testbench.sv
// self-checking bench for the segment address translator
`timescale 1ns/1ps

`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fails++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end

module testbench;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic        xl_valid, exc_event, exc_return, rs_valid, rs_cac, rs_err;
  logic        kernel_mode, cac, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, xl_vaddr, rs_paddr, r, pa, xp;
  logic [3:0]  rs_region, rg, xr;
  logic [1:0]  rs_pw, pw;
  int          fails, n_checks, cyc;
  localparam logic [31:0] WV = 32'h0618_6186;
  logic [31:0] va_t [7] = '{32'h0000_1234, 32'h7fff_fffc, 32'h3000_0000,
    32'h8123_4568, 32'hbc00_0000, 32'hc000_0004, 32'hfff0_0000};
  logic [31:0] pa_t [7] = '{32'h4000_1234, 32'hbfff_fffc, 32'h7000_0000,
    32'h0123_4568, 32'h1c00_0000, 32'hc000_0004, 32'hfff0_0000};

  sat_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .xl_valid(xl_valid), .xl_vaddr(xl_vaddr), .exc_event(exc_event),
    .exc_return(exc_return), .rs_valid(rs_valid), .rs_paddr(rs_paddr),
    .rs_cacheable(rs_cac), .rs_addr_error(rs_err), .rs_region(rs_region),
    .rs_port_width(rs_pw), .kernel_mode(kernel_mode));
  sat_core_model core_u (.pclk(pclk), .xl_valid(xl_valid),
    .xl_vaddr(xl_vaddr), .exc_event(exc_event), .exc_return(exc_return),
    .rs_valid(rs_valid), .rs_paddr(rs_paddr), .rs_cacheable(rs_cac),
    .rs_addr_error(rs_err), .rs_region(rs_region), .rs_port_width(rs_pw));

  // 10 MHz clock and a hang limit well past the expected run
  always #50 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      test_done();
    end
  end

  // one apb transfer, request held until pready is sampled
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // translate table entry i and compare against the segment rules
  task automatic xchk(input int i);
    core_u.xlate(va_t[i], pa, cac, er, rg, pw);
    xp = pa_t[i];
    xr = xp[31:29] == 3'h0 ? {1'b0, xp[28:26]} :
      xp[31:30] == 2'h3 ? {3'h6, xp[29]} : 4'h6 + {1'b0, xp[31:29]};
    `CHK(er, 1'b0)
    `CHK(pa, xp)
    `CHK(rg, xr)
    `CHK(pw, WV[2*xr +: 2])
    `CHK(pa[31:29] == 3'h0 || pa[31:30] == 2'h3, va_t[i][31])
    if (va_t[i][31:29] == 3'h4) `CHK(cac, 1'b1)
    if (va_t[i][31:29] == 3'h5) `CHK(cac, 1'b0)
  endtask : xchk

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : test_done

  // main sequence: registers, kernel and user translation, events
  initial begin
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    `CHK(kernel_mode, 1'b1)
    apb(1'b0, sat_pkg::STATUS_OFFSET, 32'h0);
    `CHK(r, 32'h1 << sat_pkg::STAT_SHUTDOWN_BIT)
    apb(1'b0, sat_pkg::WIDTH_OFFSET, 32'h0);
    `CHK(r, {4'h0, sat_pkg::WIDTH_RESET})
    apb(1'b0, 12'h010, 32'h0);
    `CHK(e, 1'b1)
    apb(1'b1, sat_pkg::WIDTH_OFFSET, WV);
    apb(1'b0, sat_pkg::WIDTH_OFFSET, 32'h0);
    `CHK(r, WV)
    for (int i = 0; i < 7; i++) xchk(i);
    apb(1'b1, sat_pkg::STATUS_OFFSET, 32'h1);
    for (int i = 0; i < 7; i++) if (!va_t[i][31]) xchk(i);
    `CHK(kernel_mode, 1'b0)
    core_u.xlate(32'h8000_0040, pa, cac, er, rg, pw);
    `CHK({er, pa}, {1'b1, 32'h0})
    `CHK(kernel_mode, 1'b1)
    apb(1'b0, sat_pkg::ERR_ADDR_OFFSET, 32'h0);
    `CHK(r, 32'h8000_0040)
    apb(1'b0, sat_pkg::XLATE_CNT_OFFSET, 32'h0);
    `CHK(r, 32'ha)
    apb(1'b0, sat_pkg::STATUS_OFFSET, 32'h0);
    `CHK(r, 32'h6)
    core_u.ev(1'b1);
    `CHK(kernel_mode, 1'b0)
    core_u.ev(1'b0);
    `CHK(kernel_mode, 1'b1)
    apb(1'b1, sat_pkg::STATUS_OFFSET, 32'h0);
    apb(1'b0, sat_pkg::STATUS_OFFSET, 32'h0);
    `CHK(r, 32'h4)
    core_u.ev(1'b1);
    `CHK(kernel_mode, 1'b1)
    apb(1'b0, sat_pkg::STATUS_OFFSET, 32'h0);
    `CHK(r, 32'h6)
    test_done();
  end
endmodule : testbench
